//--- design/bfl_pkg.sv
// shared constants and op codes for the bit, flag and load execution unit
package bfl_pkg;
	localparam int SF_C = 0;
	localparam int SF_Z = 1;
	localparam int SF_N = 2;
	localparam int SF_V = 3;
	localparam int SF_S = 4;
	localparam int SF_H = 5;
	localparam int SF_T = 6;
	localparam int SF_I = 7;
	localparam int BYTE_BITS = 8;
	localparam int MSB = 7;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [15:0] PTR_ONE = 16'h0001;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	localparam logic [9:0] DISP_PAD = 10'h000;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	typedef enum logic [4:0] {
		OP_NOP = 5'h00,
		OP_ROT_RC = 5'h01,
		OP_SHR_ARITH = 5'h02,
		OP_SWAP = 5'h03,
		OP_BSET = 5'h04,
		OP_BCLR = 5'h05,
		OP_BIT_TO_T = 5'h06,
		OP_T_TO_BIT = 5'h07,
		OP_SET_SIGN = 5'h08,
		OP_CLR_SIGN = 5'h09,
		OP_SET_OVF = 5'h0A,
		OP_CLR_OVF = 5'h0B,
		OP_SET_HALF = 5'h0C,
		OP_CLR_HALF = 5'h0D,
		OP_MOV = 5'h0E,
		OP_MOVW = 5'h0F,
		OP_LOAD_IMM = 5'h10,
		OP_LOAD_PTR = 5'h11,
		OP_LOAD_POST_INC = 5'h12,
		OP_LOAD_PRE_DEC = 5'h13,
		OP_LOAD_DISP = 5'h14,
		OP_LOAD_DIRECT = 5'h15
	} op_t;
	typedef enum logic [1:0] {
		PTR_X = 2'h0,
		PTR_Y = 2'h1,
		PTR_Z = 2'h2
	} ptr_sel_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_LOAD = 2'h1
	} state_t;
endpackage

//--- design/bit_flag_load_exec_unit.sv
// execution unit for shifts, bit transfer, flag ops, moves and data loads
`timescale 1ns/100ps
`default_nettype none

module bit_flag_load_exec_unit (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_valid,
	input wire logic [4:0] i_op,
	input wire logic [7:0] i_rd_val,
	input wire logic [7:0] i_src_val,
	input wire logic [7:0] i_src_hi_val,
	input wire logic [2:0] i_bit_sel,
	input wire logic [7:0] i_imm,
	input wire logic [5:0] i_disp,
	input wire logic [15:0] i_addr,
	input wire logic [1:0] i_ptr_sel,
	input wire logic [15:0] i_ptr_val,
	input wire logic [7:0] i_mem_rdata,
	output logic o_ready,
	output logic o_mem_re,
	output logic [15:0] o_mem_addr,
	output logic o_rd_we,
	output logic [7:0] o_rd_data,
	output logic o_rd_hi_we,
	output logic [7:0] o_rd_hi_data,
	output logic o_ptr_we,
	output logic [1:0] o_ptr_wsel,
	output logic [15:0] o_ptr_wdata,
	output logic o_done,
	output logic [7:0] o_status_flags
);
	bfl_pkg::state_t state_reg;
	bfl_pkg::state_t state_next;
	bfl_pkg::op_t op;
	logic [7:0] status_flags_reg;
	logic [7:0] status_flags_next;
	logic [7:0] alu_res;
	logic alu_c;
	logic [7:0] bit_mask;
	logic [15:0] eff_addr;
	logic [15:0] ptr_dec;
	logic [15:0] ptr_inc;
	logic [15:0] disp_addr;
	logic taken;
	logic in_load;
	logic load_start;
	logic is_rot;
	logic is_shr;
	logic is_swap;
	logic is_bset;
	logic is_bclr;
	logic is_bit_to_t;
	logic is_t_to_bit;
	logic is_mov;
	logic is_movw;
	logic is_imm;
	logic is_load_ptr;
	logic is_load_inc;
	logic is_load_dec;
	logic is_load_disp;
	logic is_load_dir;
	logic is_shift;
	logic is_mem_load;
	logic ptr_update;
	logic single_wr;
	logic shift_z;
	logic shift_n;
	logic shift_v;
	logic rd_we_reg;
	logic [7:0] rd_data_reg;

	// decode once into one-bit selects; the eff_addr, alu_res and flag blocks still case on op
	assign op = bfl_pkg::op_t'(i_op);
	assign o_ready = (state_reg == bfl_pkg::ST_IDLE);
	assign in_load = (state_reg == bfl_pkg::ST_LOAD);
	assign taken = i_valid && o_ready;
	assign is_rot = (op == bfl_pkg::OP_ROT_RC);
	assign is_shr = (op == bfl_pkg::OP_SHR_ARITH);
	assign is_swap = (op == bfl_pkg::OP_SWAP);
	assign is_bset = (op == bfl_pkg::OP_BSET);
	assign is_bclr = (op == bfl_pkg::OP_BCLR);
	assign is_bit_to_t = (op == bfl_pkg::OP_BIT_TO_T);
	assign is_t_to_bit = (op == bfl_pkg::OP_T_TO_BIT);
	assign is_mov = (op == bfl_pkg::OP_MOV);
	assign is_movw = (op == bfl_pkg::OP_MOVW);
	assign is_imm = (op == bfl_pkg::OP_LOAD_IMM);
	assign is_load_ptr = (op == bfl_pkg::OP_LOAD_PTR);
	assign is_load_inc = (op == bfl_pkg::OP_LOAD_POST_INC);
	assign is_load_dec = (op == bfl_pkg::OP_LOAD_PRE_DEC);
	assign is_load_disp = (op == bfl_pkg::OP_LOAD_DISP);
	assign is_load_dir = (op == bfl_pkg::OP_LOAD_DIRECT);
	assign is_shift = is_rot || is_shr;
	assign is_mem_load = is_load_ptr || is_load_inc || is_load_dec || is_load_disp || is_load_dir;
	assign ptr_update = is_load_inc || is_load_dec;
	assign load_start = taken && is_mem_load;
	assign single_wr = taken && (is_shift || is_swap || is_t_to_bit || is_mov || is_movw || is_imm);

	assign ptr_dec = i_ptr_val - bfl_pkg::PTR_ONE;
	assign ptr_inc = i_ptr_val + bfl_pkg::PTR_ONE;
	assign disp_addr = i_ptr_val + {bfl_pkg::DISP_PAD, i_disp};

	// one-hot mask for the chosen bit
	genvar gi;
	generate
		for (gi = 0; gi < bfl_pkg::BYTE_BITS; gi++) begin : g_mask
			assign bit_mask[gi] = (i_bit_sel == 3'(gi));
		end
	endgenerate

	always_comb begin
		eff_addr = i_ptr_val;
		case (op)
			bfl_pkg::OP_LOAD_PRE_DEC: eff_addr = ptr_dec;
			bfl_pkg::OP_LOAD_DISP: eff_addr = disp_addr;
			bfl_pkg::OP_LOAD_DIRECT: eff_addr = i_addr;
			default: eff_addr = i_ptr_val;
		endcase
	end

	always_comb begin
		alu_res = i_rd_val;
		alu_c = status_flags_reg[bfl_pkg::SF_C];
		case (op)
			bfl_pkg::OP_ROT_RC: begin
				alu_res = {status_flags_reg[bfl_pkg::SF_C], i_rd_val[7:1]};
				alu_c = i_rd_val[0];
			end
			bfl_pkg::OP_SHR_ARITH: begin
				alu_res = {i_rd_val[7], i_rd_val[7:1]};
				alu_c = i_rd_val[0];
			end
			bfl_pkg::OP_SWAP: alu_res = {i_rd_val[3:0], i_rd_val[7:4]};
			bfl_pkg::OP_T_TO_BIT: alu_res = status_flags_reg[bfl_pkg::SF_T] ?
				(i_rd_val | bit_mask) : (i_rd_val & ~bit_mask);
			bfl_pkg::OP_MOV: alu_res = i_src_val;
			bfl_pkg::OP_MOVW: alu_res = i_src_val;
			bfl_pkg::OP_LOAD_IMM: alu_res = i_imm;
			default: alu_res = i_rd_val;
		endcase
	end

	// V is N xor C and S is N xor V, which leaves S equal to the carry out
	assign shift_z = (alu_res == bfl_pkg::BYTE_ZERO);
	assign shift_n = alu_res[bfl_pkg::MSB];
	assign shift_v = shift_n ^ alu_c;

	always_comb begin
		status_flags_next = status_flags_reg;
		if (taken) begin
			case (op)
				bfl_pkg::OP_ROT_RC, bfl_pkg::OP_SHR_ARITH: begin
					status_flags_next[bfl_pkg::SF_C] = alu_c;
					status_flags_next[bfl_pkg::SF_Z] = shift_z;
					status_flags_next[bfl_pkg::SF_N] = shift_n;
					status_flags_next[bfl_pkg::SF_V] = shift_v;
					status_flags_next[bfl_pkg::SF_S] = alu_c;
				end
				bfl_pkg::OP_BSET: status_flags_next = status_flags_reg | bit_mask;
				bfl_pkg::OP_BCLR: status_flags_next = status_flags_reg & ~bit_mask;
				bfl_pkg::OP_BIT_TO_T: status_flags_next[bfl_pkg::SF_T] = |(i_src_val & bit_mask);
				bfl_pkg::OP_SET_SIGN: status_flags_next[bfl_pkg::SF_S] = 1'b1;
				bfl_pkg::OP_CLR_SIGN: status_flags_next[bfl_pkg::SF_S] = 1'b0;
				bfl_pkg::OP_SET_OVF: status_flags_next[bfl_pkg::SF_V] = 1'b1;
				bfl_pkg::OP_CLR_OVF: status_flags_next[bfl_pkg::SF_V] = 1'b0;
				bfl_pkg::OP_SET_HALF: status_flags_next[bfl_pkg::SF_H] = 1'b1;
				bfl_pkg::OP_CLR_HALF: status_flags_next[bfl_pkg::SF_H] = 1'b0;
				default: status_flags_next = status_flags_reg;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			status_flags_reg <= bfl_pkg::FLAGS_RESET;
		end else begin
			status_flags_reg <= status_flags_next;
		end
	end

	assign o_status_flags = status_flags_reg;

	// two-cycle load: address and read enable out in the second cycle, data taken back in that same cycle
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			bfl_pkg::ST_IDLE: begin
				if (load_start) begin
					state_next = bfl_pkg::ST_LOAD;
				end
			end
			bfl_pkg::ST_LOAD: state_next = bfl_pkg::ST_IDLE;
			default: state_next = bfl_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= bfl_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_mem_re <= 1'b0;
		end else begin
			o_mem_re <= load_start;
		end
	end

	// address holds after the load so a slow memory still sees it
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_mem_addr <= bfl_pkg::WORD_ZERO;
		end else begin
			if (load_start) begin
				o_mem_addr <= eff_addr;
			end
		end
	end

	// pointer write-back only for the post-increment and pre-decrement forms
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ptr_we <= 1'b0;
		end else begin
			o_ptr_we <= load_start && ptr_update;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ptr_wsel <= bfl_pkg::PTR_X;
		end else begin
			if (load_start) begin
				o_ptr_wsel <= i_ptr_sel;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ptr_wdata <= bfl_pkg::WORD_ZERO;
		end else begin
			if (load_start) begin
				o_ptr_wdata <= is_load_inc ? ptr_inc : ptr_dec;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_we_reg <= 1'b0;
		end else begin
			rd_we_reg <= single_wr;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_data_reg <= bfl_pkg::BYTE_ZERO;
		end else begin
			if (single_wr) begin
				rd_data_reg <= alu_res;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rd_hi_we <= 1'b0;
		end else begin
			o_rd_hi_we <= taken && is_movw;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rd_hi_data <= bfl_pkg::BYTE_ZERO;
		end else begin
			if (taken && is_movw) begin
				o_rd_hi_data <= i_src_hi_val;
			end
		end
	end

	// done marks the result cycle, one cycle after acceptance: cycle two of a load and of every other op
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_done <= 1'b0;
		end else begin
			o_done <= taken;
		end
	end

	// memory data is used in the second cycle, so a mux and no register here
	assign o_rd_we = rd_we_reg || in_load;
	assign o_rd_data = in_load ? i_mem_rdata : rd_data_reg;
endmodule // bit_flag_load_exec_unit

`default_nettype wire

//--- test/bfl_properties.sv
// timing and data properties of the execution unit
`timescale 1ns/100ps
`default_nettype none
module bfl_properties (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_valid,
	input wire logic [4:0] i_op,
	input wire logic [7:0] i_rd_val,
	input wire logic [15:0] i_ptr_val,
	input wire logic o_ready,
	input wire logic o_mem_re,
	input wire logic [15:0] o_mem_addr,
	input wire logic o_done,
	input wire logic [7:0] o_rd_data,
	input wire logic o_ptr_we,
	input wire logic [15:0] o_ptr_wdata,
	input wire logic [7:0] o_status_flags
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	wire logic tk = i_valid && o_ready;
	load_two_cycle_a: assert property (tk && i_op >= 5'h11 && i_op <= 5'h15 |=>
		o_mem_re && o_done && !o_ready ##1 o_ready) else $error("load slot timing wrong");
	single_cycle_a: assert property (tk && i_op != 5'h00 && i_op < 5'h11 |=>
		o_done && !o_mem_re && o_ready) else $error("single cycle op timing wrong");
	rotate_data_a: assert property (tk && i_op == 5'h01 |=>
		o_rd_data == {$past(o_status_flags[0]), $past(i_rd_val[7:1])}
		&& o_status_flags[0] == $past(i_rd_val[0])) else $error("rotate result wrong");
	arith_shift_a: assert property (tk && i_op == 5'h02 |=>
		o_rd_data == {$past(i_rd_val[7]), $past(i_rd_val[7:1])}) else $error("shift wrong");
	nibble_swap_a: assert property (tk && i_op == 5'h03 |=>
		o_rd_data == {$past(i_rd_val[3:0]), $past(i_rd_val[7:4])}
		&& $stable(o_status_flags)) else $error("swap wrong");
	sign_set_a: assert property (tk && i_op == 5'h08 |=>
		o_status_flags == ($past(o_status_flags) | 8'h10)) else $error("sign set wrong");
	ovf_clear_a: assert property (tk && i_op == 5'h0B |=>
		o_status_flags == ($past(o_status_flags) & 8'hF7)) else $error("overflow clear wrong");
	post_inc_a: assert property (tk && i_op == 5'h12 |=> o_ptr_we
		&& o_mem_addr == $past(i_ptr_val) && o_ptr_wdata == o_mem_addr + 16'h0001)
		else $error("post increment wrong");
	pre_dec_a: assert property (tk && i_op == 5'h13 |=> o_ptr_we
		&& o_ptr_wdata == $past(i_ptr_val) - 16'h0001 && o_mem_addr == o_ptr_wdata)
		else $error("pre decrement wrong");
	cover property (tk && i_op == 5'h12);
	cover property (tk && i_op == 5'h01);
	cover property (tk && i_op == 5'h0C);
endmodule // bfl_properties
bind bit_flag_load_exec_unit bfl_properties chk (.*);
`default_nettype wire

//--- test/test_bit_flag_load_exec_unit.sv
// self-checking bench for the execution unit
`timescale 1ns/100ps
`default_nettype none
module test_bit_flag_load_exec_unit;
	logic i_clk = 0, i_rst_n = 0, i_valid = 0;
	logic [4:0] i_op = 5'h00;
	logic [15:0] v = 16'h0000;
	logic [7:0] f = 8'h00;
	int miscompares = 0, n_checks = 0, cyc = 0;
	logic o_ready, o_mem_re, o_rd_we, o_rd_hi_we, o_ptr_we, o_done;
	logic [15:0] o_mem_addr, o_ptr_wdata;
	logic [7:0] o_rd_data, o_rd_hi_data, o_status_flags;
	logic [1:0] o_ptr_wsel;
	// one stimulus word feeds every operand but i_mem_rdata, made from o_mem_addr, so no input sits tied
	wire logic [7:0] i_rd_val = v[7:0], i_src_val = v[15:8], i_imm = v[15:8];
	wire logic [7:0] i_src_hi_val = ~v[15:8], i_mem_rdata = o_mem_addr[7:0] ^ 8'h5A;
	wire logic [2:0] i_bit_sel = v[2:0];
	wire logic [5:0] i_disp = v[5:0];
	wire logic [15:0] i_addr = v, i_ptr_val = v;
	wire logic [1:0] i_ptr_sel = v[9:8];
	bit_flag_load_exec_unit uut (.*);
	initial forever #5 i_clk = ~i_clk;
	task automatic tally_and_finish();
		$display("checks=%0d miscompares=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 1000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// no back-to-back issue: a load always gets its bubble
	task automatic go(input logic [4:0] op, input logic [15:0] val);
		@(posedge i_clk);
		i_valid <= 1'b1;
		i_op <= op;
		v <= val;
		@(posedge i_clk);
		i_valid <= 1'b0;
		#1;
	endtask
	task automatic t_shift();
		go(5'h04, 16'h0000);
		go(5'h01, 16'h0081);
		chk({o_done, o_rd_we, o_rd_data}, 16'h03C0);
		chk(o_status_flags, 8'h15);
		go(5'h02, 16'h0084);
		chk(o_rd_data, 8'hC2);
		chk(o_status_flags, 8'h0C);
		go(5'h03, 16'h00A5);
		chk(o_rd_data, 8'h5A);
		chk(o_status_flags, 8'h0C);
	endtask
	task automatic t_bits();
		go(5'h06, 16'h2005);
		chk(o_status_flags, 8'h4C);
		go(5'h07, 16'h0003);
		chk(o_rd_data, 8'h0B);
		chk(o_status_flags, 8'h4C);
		f = 8'h4C;
	endtask
	task automatic t_flags();
		int b;
		for (int i = 0; i < 6; i++) begin
			b = (i < 2) ? 4 : (i < 4) ? 3 : 5;
			f = i[0] ? f & ~(8'h01 << b) : f | (8'h01 << b);
			go(5'h08 + i[4:0], 16'h0000);
			chk(o_status_flags, f);
		end
	endtask
	task automatic t_load();
		logic [15:0] ea [5] = '{16'h1230, 16'h1230, 16'h122F, 16'h1260, 16'h1230};
		for (int i = 0; i < 5; i++) begin
			go(5'h11 + i[4:0], 16'h1230);
			chk({o_ready, o_done, o_mem_re}, 16'h0003);
			chk(o_mem_addr, ea[i]);
			chk(o_rd_data, ea[i][7:0] ^ 8'h5A);
			chk(o_ptr_we, i == 1 || i == 2);
			if (i == 1 || i == 2) begin
				chk(o_ptr_wdata, (i == 1) ? 16'h1231 : 16'h122F);
				chk(o_ptr_wsel, 16'h0002);
			end
			chk(o_status_flags, f);
		end
	endtask
	task automatic t_moves();
		go(5'h0E, 16'h3C00);
		chk({o_rd_we, o_rd_hi_we, o_rd_data}, 16'h023C);
		chk(o_status_flags, 8'h44);
		go(5'h0F, 16'h5A00);
		chk({o_rd_we, o_rd_hi_we, o_rd_data}, 16'h035A);
		chk(o_rd_hi_data, 8'hA5);
		go(5'h10, 16'h7E00);
		chk({o_rd_we, o_rd_data}, 16'h017E);
		go(5'h05, 16'h0002);
		chk(o_status_flags, 8'h40);
		go(5'h00, 16'h0000);
		chk({o_done, o_rd_we, o_mem_re}, 16'h0004);
	endtask
	initial begin
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'b1;
		t_shift();
		t_bits();
		t_flags();
		t_load();
		t_moves();
		tally_and_finish();
	end
endmodule // test_bit_flag_load_exec_unit
`default_nettype wire
